// file: design/ptb_timebase.sv
// Function
// - Disabled unit holds divider chain at zero; counts up once enabled.
// - Overflow at selected tap sets pending flag; flag read-only.
// - Interrupt request while pending flag and interrupt enable both set.
// - Writing one to acknowledge clears pending flag; zero has no effect.
// - Acknowledge bit holds no state and always reads zero.
// - First flag after enable at about half period, then exact period.
// - Rate codes give dividers 32768,8192,2048,128,64,32,16,8.
// - Extra predivide option multiplies every divider by 128.
// - Divider chain has fifteen binary stages with eight selectable taps.
// - Chain is stepped by oscillator clock ticks from clock generator.
// - Counting continues in wait mode; register access blocked there.
// - In stop mode runs only if oscillator runs in stop.
// - Register access blocked while in stop mode.
// - Reset clears unit enable and interrupt enable.
// - Disable then enable restarts the divider chain from zero.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "ptb_regs.svh"
module ptb_timebase
	import ptb_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output      logic [7:0] rdata,
	input  wire logic       oscTick,
	input  wire logic       extraPredivOption,
	input  wire logic       oscRunInStopOption,
	input  wire logic       waitMode,
	input  wire logic       stopMode,
	output      logic       periodIrq,
	output      logic       stopWakeup,
	output      logic       irqOut
);
	// ****************************************
	// Reset release and input synchronisers
	// ****************************************
	logic rstMeta;
	logic rstSync;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	logic tickSync;
	logic preSync;
	logic oscStopSync;
	logic waitSync;
	logic stopSync;

	ptb_sync2 uSyncTick
	(
		.core_clk (core_clk),
		.rstn     (rstSync),
		.din      (oscTick),
		.dout     (tickSync)
	);

	ptb_sync2 uSyncPre
	(
		.core_clk (core_clk),
		.rstn     (rstSync),
		.din      (extraPredivOption),
		.dout     (preSync)
	);

	ptb_sync2 uSyncOscStop
	(
		.core_clk (core_clk),
		.rstn     (rstSync),
		.din      (oscRunInStopOption),
		.dout     (oscStopSync)
	);

	ptb_sync2 uSyncWait
	(
		.core_clk (core_clk),
		.rstn     (rstSync),
		.din      (waitMode),
		.dout     (waitSync)
	);

	ptb_sync2 uSyncStop
	(
		.core_clk (core_clk),
		.rstn     (rstSync),
		.din      (stopMode),
		.dout     (stopSync)
	);

	// ****************************************
	// State
	// ****************************************
	ptb_bus_t                   bus;
	ptb_ctrl_t                  ctrl;
	ptb_ctrl_t                  next_ctrl;
	ptb_mode_t                  mode;
	logic                       tickPrev;
	logic                       next_tickPrev;
	logic [`PTB_PREDIV_W-1:0]   prediv;
	logic [`PTB_PREDIV_W-1:0]   next_prediv;
	logic [`PTB_CHAIN_W-1:0]    chain;
	logic [`PTB_CHAIN_W-1:0]    next_chain;
	logic                       pending;
	logic                       next_pending;
	logic [1:0]                 evStatus;
	logic [1:0]                 next_evStatus;
	logic [1:0]                 evMask;
	logic [1:0]                 next_evMask;
	logic [7:0]                 next_rdata;
	logic                       next_periodIrq;
	logic                       next_stopWakeup;
	logic                       next_irqOut;
	logic                       countStep;
	logic                       chainStep;
	logic                       tapHit;
	logic                       running;
	logic                       access;
	logic [`PTB_CHAIN_W-1:0]    nextCount;
	logic [7:0]                 controlView;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ****************************************
	// Power mode
	// ****************************************
	always_comb
	begin
		case ({stopSync, waitSync})
			2'b00:   mode = PTB_RUN;
			2'b01:   mode = PTB_WAIT;
			default: mode = PTB_STOP;
		endcase
	end

	// Wait keeps counting; stop only with the oscillator kept alive
	always_comb
	begin
		case (mode)
			PTB_RUN:  running = 1'b1;
			PTB_WAIT: running = 1'b1;
			PTB_STOP: running = oscStopSync;
			default:  running = 1'b0;
		endcase
	end

	assign access = (mode == PTB_RUN);

	// ****************************************
	// Divider chain
	// ****************************************
	// Oscillator tick edge counts one step; it clocks the chain directly unless the predivide is on
	assign countStep = tickSync & ~tickPrev & ctrl.unitEnable & running;
	// Optional divide by 128 ahead of the chain
	assign chainStep = countStep & (!preSync || (&prediv));
	assign nextCount = chain + 15'h0001;

	// ****************************************
	// Tap selection
	// ****************************************
	// The tap bit rising from 0 to 1 marks the event. Bit k toggles every
	// 2^k steps, so from a cleared chain the first rise comes after half
	// the divider and every later rise a full divider on. Watching the
	// fall instead would push the first event out to a full period.
	always_comb
	begin
		case (ctrl.rateSelect)
			3'h0:    tapHit = ~chain[14] & nextCount[14];
			3'h1:    tapHit = ~chain[12] & nextCount[12];
			3'h2:    tapHit = ~chain[10] & nextCount[10];
			3'h3:    tapHit = ~chain[6] & nextCount[6];
			3'h4:    tapHit = ~chain[5] & nextCount[5];
			3'h5:    tapHit = ~chain[4] & nextCount[4];
			3'h6:    tapHit = ~chain[3] & nextCount[3];
			default: tapHit = ~chain[2] & nextCount[2];
		endcase
	end

	always_comb
	begin
		next_tickPrev = tickSync;
		next_prediv   = prediv;
		next_chain    = chain;
		if (!ctrl.unitEnable)
		begin
			next_prediv = '0;
			next_chain  = '0;
		end
		else
		begin
			if (countStep)
				next_prediv = prediv + 7'h01;
			if (chainStep)
				next_chain = nextCount;
		end
	end

	// ****************************************
	// Register access and flags
	// ****************************************
	always_comb
	begin
		controlView                  = 8'h00;
		controlView[`PTB_BIT_PENDING] = pending;
		controlView[`PTB_BIT_RATE_HI:`PTB_BIT_RATE_LO] = ctrl.rateSelect;
		controlView[`PTB_BIT_ACK]    = 1'b0;
		controlView[`PTB_BIT_IRQEN]  = ctrl.periodIrqEnable;
		controlView[`PTB_BIT_ENABLE] = ctrl.unitEnable;
	end

	always_comb
	begin
		next_ctrl     = ctrl;
		next_pending  = pending;
		next_evStatus = evStatus;
		next_evMask   = evMask;
		next_rdata    = 8'h00;
		if (access && bus.wr)
		begin
			case (bus.addr)
				`PTB_OFS_CONTROL:
				begin
					next_ctrl.rateSelect      = bus.wdata[`PTB_BIT_RATE_HI:`PTB_BIT_RATE_LO];
					next_ctrl.periodIrqEnable = bus.wdata[`PTB_BIT_IRQEN];
					next_ctrl.unitEnable      = bus.wdata[`PTB_BIT_ENABLE];
					if (bus.wdata[`PTB_BIT_ACK])
						next_pending = 1'b0;
				end
				`PTB_OFS_MASK:
					next_evMask = bus.wdata[1:0];
				default:
					next_evMask = evMask;
			endcase
		end
		if (access && bus.rd)
		begin
			case (bus.addr)
				`PTB_OFS_CONTROL: next_rdata = controlView;
				`PTB_OFS_STATUS:
				begin
					next_rdata    = {6'h00, evStatus};
					next_evStatus = 2'h0;
				end
				`PTB_OFS_MASK:    next_rdata = {6'h00, evMask};
				default:          next_rdata = 8'h00;
			endcase
		end
		// Hardware set wins over any clear in the same cycle
		if (chainStep && tapHit)
		begin
			next_pending     = 1'b1;
			next_evStatus[0] = 1'b1;
			if (mode == PTB_STOP)
				next_evStatus[1] = 1'b1;
		end
	end

	// ****************************************
	// Interrupt outputs
	// ****************************************
	// Built from the next flag values so that each output flip-flop
	// moves on the same edge as the flag behind it.
	always_comb
	begin
		next_periodIrq  = next_pending & next_ctrl.periodIrqEnable;
		next_stopWakeup = next_periodIrq & (mode == PTB_STOP);
		next_irqOut     = |(next_evStatus & next_evMask);
	end

	// ****************************************
	// Registers
	// ****************************************
	// Divider chain group
	always_ff @(posedge core_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			tickPrev <= 1'b0;
			prediv   <= '0;
			chain    <= '0;
		end
		else
		begin
			tickPrev <= next_tickPrev;
			prediv   <= next_prediv;
			chain    <= next_chain;
		end
	end

	// Control and flag group
	always_ff @(posedge core_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			ctrl.rateSelect      <= 3'(`PTB_CONTROL_RST >> `PTB_BIT_RATE_LO);
			ctrl.periodIrqEnable <= 1'(`PTB_CONTROL_RST >> `PTB_BIT_IRQEN);
			ctrl.unitEnable      <= 1'(`PTB_CONTROL_RST >> `PTB_BIT_ENABLE);
			pending              <= 1'b0;
			evStatus             <= `PTB_EVENT_RST;
			evMask               <= `PTB_EVENT_RST;
			rdata                <= 8'h00;
		end
		else
		begin
			ctrl     <= next_ctrl;
			pending  <= next_pending;
			evStatus <= next_evStatus;
			evMask   <= next_evMask;
			rdata    <= next_rdata;
		end
	end

	// Interrupt output group
	always_ff @(posedge core_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			periodIrq  <= 1'b0;
			stopWakeup <= 1'b0;
			irqOut     <= 1'b0;
		end
		else
		begin
			periodIrq  <= next_periodIrq;
			stopWakeup <= next_stopWakeup;
			irqOut     <= next_irqOut;
		end
	end
endmodule // ptb_timebase

// file: design/ptb_regs.svh
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH
// ****************************************
// Register map
// ****************************************
`define PTB_ADDR_W        4
`define PTB_OFS_CONTROL   4'h0
`define PTB_OFS_STATUS    4'h1
`define PTB_OFS_MASK      4'h2
// ****************************************
// Control register fields
// ****************************************
`define PTB_BIT_PENDING   7
`define PTB_BIT_RATE_HI   6
`define PTB_BIT_RATE_LO   4
`define PTB_BIT_ACK       3
`define PTB_BIT_IRQEN     2
`define PTB_BIT_ENABLE    1
`define PTB_CONTROL_RST   8'h00
`define PTB_EVENT_RST     2'h0
// ****************************************
// Divider chain
// ****************************************
`define PTB_CHAIN_W       15
`define PTB_PREDIV_W      7
`endif

// file: design/ptb_pkg.sv
package ptb_pkg;
	typedef struct packed {
		logic [2:0] rateSelect;
		logic       periodIrqEnable;
		logic       unitEnable;
	} ptb_ctrl_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ptb_bus_t;

	typedef enum logic [1:0] {
		PTB_RUN  = 2'b00,
		PTB_WAIT = 2'b01,
		PTB_STOP = 2'b10
	} ptb_mode_t;
endpackage

// file: design/ptb_sync2.sv
`timescale 1ns/10ps
module ptb_sync2
(
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic din,
	output      logic dout
);
	logic stage1;
	logic next_stage1;
	logic next_dout;

	always_comb
	begin
		next_stage1 = din;
		next_dout   = stage1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1 <= 1'b0;
			dout   <= 1'b0;
		end
		else
		begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end
endmodule // ptb_sync2

// file: sim/ptb_timebase_monitor.sv
`timescale 1ns/10ps
module ptb_timebase_monitor
(
	input wire logic       core_clk,
	input wire logic       rstn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       waitMode,
	input wire logic       stopMode,
	input wire logic       periodIrq,
	input wire logic       stopWakeup,
	input wire logic       irqOut
);
	// ****
	// Port rules
	// ****
	logic acc;
	assign acc = !waitMode && !stopMode;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_ack_reads0: assert property ($past(rd) && $past(addr) == 4'h0 |-> !rdata[3])
		else $error("ack bit read nonzero");
	a_spare_zero: assert property ($past(rd) && $past(addr) == 4'h0 |-> !rdata[0])
		else $error("spare bit read nonzero");
	a_unmapped_zero: assert property ($past(rd) && $past(addr) > 4'h2 |-> rdata == 8'h00)
		else $error("unmapped read nonzero");
	a_irq_off: assert property (wr && addr == 4'h0 && !wdata[2] && acc |-> ##2 !periodIrq)
		else $error("irq with enable clear");
	a_mask_off: assert property (wr && addr == 4'h2 && wdata[1:0] == 2'h0 && acc |-> ##2 !irqOut)
		else $error("irq out with mask clear");
	a_wait_refused: assert property (waitMode[*4] ##0 rd |=> rdata == 8'h00)
		else $error("read served in wait");
	a_stop_refused: assert property (stopMode[*4] ##0 rd |=> rdata == 8'h00)
		else $error("read served in stop");
	a_wake_cause: assert property (stopWakeup |-> periodIrq && $past(stopMode, 3))
		else $error("wakeup without irq");
	a_no_wake_run: assert property ((!stopMode)[*6] |=> !stopWakeup)
		else $error("wakeup outside stop");
	a_reset_quiet: assert property ($rose(rstn) |-> !periodIrq && !irqOut)
		else $error("irq high after reset");
endmodule // ptb_timebase_monitor

bind ptb_timebase ptb_timebase_monitor ptb_timebase_monitor_inst (.core_clk, .rstn, .addr,
	.wdata, .wr, .rd, .rdata, .waitMode, .stopMode, .periodIrq, .stopWakeup, .irqOut);

// file: sim/ptb_timebase_tb.sv
`timescale 1ns/10ps
module ptb_timebase_tb;
	logic       core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, oscTick = 1'b0;
	logic       extraPredivOption = 1'b0, oscRunInStopOption = 1'b0;
	logic       waitMode = 1'b0, stopMode = 1'b0, periodIrq, stopWakeup, irqOut;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic [1:0] ph = 2'h0;
	int         err_total = 0, check_count = 0, cyc = 0, nTick = 0, tw;
	int         dv[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

	ptb_timebase ptb_timebase_inst (.core_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .oscTick,
		.extraPredivOption, .oscRunInStopOption, .waitMode, .stopMode, .periodIrq, .stopWakeup,
		.irqOut);

	always #5 core_clk = ~core_clk;
	// Oscillator at a quarter of the core rate: two cycles high, two low
	always @(posedge core_clk)
	begin
		ph <= ph + 2'h1;
		oscTick <= ph[1];
		if (ph == 2'h1) nTick <= nTick + 1;
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic chkN(input string n, input int e, input int s);
		check_count++;
		if (s != e)
		begin
			err_total++;
			$display("mismatch %s exp %0d got %0d", n, e, s);
		end
	endtask
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdReg(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
		@(posedge core_clk);
	endtask
	task automatic waitIrq(output int t);
		int n;
		n = 0;
		// Looked at off the edge, where the flag has settled
		@(negedge core_clk);
		while (periodIrq !== 1'b1 && n < 17000)
		begin
			@(negedge core_clk);
			n++;
		end
		chkN("irqseen", 1, int'(n < 17000));
		t = nTick;
		@(posedge core_clk);
	endtask
	// Restart, then first event near half and, with full set, the next one at the full divider
	task automatic period(input logic [7:0] c, input int div, input bit full);
		int t0, t1, t2;
		wrReg(4'h0, 8'h08);
		t0 = nTick;
		wrReg(4'h0, c);
		waitIrq(t1);
		chkN("half", 1, int'((t1 - t0) * 2 >= div && (t1 - t0) * 2 <= div + 4));
		if (full)
		begin
			wrReg(4'h0, c | 8'h08);
			repeat (4) @(posedge core_clk);
			waitIrq(t2);
			chkN("period", div, t2 - t1);
		end
	endtask

	initial
	begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdReg(4'h0, 8'h00);
		rdReg(4'h5, 8'h00);
		period(8'h16, dv[1], 1'b0);
		for (int i = 2; i < 8; i++)
			period({1'b0, 3'(i), 4'h6}, dv[i], 1'b1);
		extraPredivOption <= 1'b1;
		repeat (4) @(posedge core_clk);
		period(8'h76, 1024, 1'b1);
		extraPredivOption <= 1'b0;
		wrReg(4'h0, 8'h72);
		repeat (40) @(posedge core_clk);
		chk("irq", 8'h00, {7'h0, periodIrq});
		rdReg(4'h0, 8'hf2);
		wrReg(4'h0, 8'h00);
		wrReg(4'h0, 8'h7e);
		waitMode <= 1'b1;
		repeat (4) @(posedge core_clk);
		wrReg(4'h0, 8'h00);
		rdReg(4'h0, 8'h00);
		waitIrq(tw);
		waitMode <= 1'b0;
		repeat (4) @(posedge core_clk);
		rdReg(4'h0, 8'hf6);
		wrReg(4'h0, 8'h00);
		wrReg(4'h0, 8'h7e);
		stopMode <= 1'b1;
		repeat (60) @(posedge core_clk);
		chk("irq", 8'h00, {7'h0, periodIrq});
		rdReg(4'h0, 8'h00);
		oscRunInStopOption <= 1'b1;
		waitIrq(tw);
		repeat (2) @(posedge core_clk);
		chk("wake", 8'h01, {7'h0, stopWakeup});
		stopMode <= 1'b0;
		oscRunInStopOption <= 1'b0;
		repeat (4) @(posedge core_clk);
		wrReg(4'h2, 8'h01);
		repeat (3) @(posedge core_clk);
		chk("irqOut", 8'h01, {7'h0, irqOut});
		wrReg(4'h0, 8'h00);
		rdReg(4'h1, 8'h03);
		repeat (3) @(posedge core_clk);
		chk("irqOut", 8'h00, {7'h0, irqOut});
		rdReg(4'h1, 8'h00);
		wrReg(4'h2, 8'h00);
		finish_test();
	end
endmodule // ptb_timebase_tb
